//--- pkg/csbr_defs.svh
/*
 * Addresses, bit positions and reset values of the core status and bank registers.
 * Assumes the special function registers sit in the low data memory addresses.
 */
`ifndef CSBR_DEFS_SVH
`define CSBR_DEFS_SVH

// special function register addresses in data memory
`define CSBR_ADDR_BP     8'h04
`define CSBR_ADDR_ACC    8'h05
`define CSBR_ADDR_PCL    8'h06
`define CSBR_ADDR_TABLE_POINTER   8'h07
`define CSBR_ADDR_TABLE_HIGH_BYTE   8'h08
`define CSBR_ADDR_STATUS 8'h0a

// bit positions
`define CSBR_BIT_BANK 0
`define CSBR_BIT_C    0
`define CSBR_BIT_AC   1
`define CSBR_BIT_Z    2
`define CSBR_BIT_OV   3
`define CSBR_BIT_PDF  4
`define CSBR_BIT_TO   5

// reset values
`define CSBR_BANK_RST 1'b0
`define CSBR_FLAG_RST 1'b0
`define CSBR_SYS_RST  1'b0
`define CSBR_BYTE_RST 8'h00

`endif

//--- pkg/csbr_pkg.sv
/*
 * Types of the core status and bank register block: operations and sequencer states.
 * Assumes the execution core decodes instructions into these operations.
 */
package csbr_pkg;

    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_MOVA  = 4'h1,
        OP_MOVM  = 4'h2,
        OP_ADD   = 4'h3,
        OP_ADC   = 4'h4,
        OP_SUB   = 4'h5,
        OP_SBC   = 4'h6,
        OP_AND   = 4'h7,
        OP_OR    = 4'h8,
        OP_XOR   = 4'h9,
        OP_INC   = 4'ha,
        OP_DEC   = 4'hb,
        OP_RLC   = 4'hc,
        OP_RRC   = 4'hd,
        OP_CLR   = 4'he,
        OP_TABRD = 4'hf
    } csbr_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TBL   = 2'b01,
        ST_DUMMY = 2'b11
    } csbr_state_e;

endpackage

//--- logic/csbr_alu.sv
/*
 * Combinational ALU: result and flag candidates for one operation.
 * Assumes the caller decides whether the operation is taken.
 */
`timescale 1ns/1ps
module csbr_alu (
    // operation
    input csbr_pkg::csbr_op_e i_op,
    input logic [7:0] i_acc,
    input logic [7:0] i_opnd,
    input logic i_carry,
    // result
    output logic [7:0] o_res,
    output logic o_c,
    output logic o_ac,
    output logic o_ov,
    output logic o_z,
    // which flags the operation affects
    output logic o_upd_arith,
    output logic o_upd_z,
    output logic o_upd_c
);

    // returns {carry out, carry into bit 7, carry out of low nibble, sum}
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [4:0] lo;
        logic [7:0] mid;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {full[8], mid[7], lo[4], full[7:0]};
    endfunction

    logic [10:0] sum;
    logic [10:0] step;

    always_comb begin
        sum = 11'h000;
        step = 11'h000;
        o_res = 8'h00;
        o_c = i_carry;
        o_ac = 1'b0;
        o_ov = 1'b0;
        o_upd_arith = 1'b0;
        o_upd_z = 1'b0;
        o_upd_c = 1'b0;
        case (i_op)
            csbr_pkg::OP_ADD, csbr_pkg::OP_ADC, csbr_pkg::OP_SUB, csbr_pkg::OP_SBC: begin
                // subtraction adds the complement; carry out then means no borrow
                case (i_op)
                    csbr_pkg::OP_ADD: sum = add8(i_acc, i_opnd, 1'b0);
                    csbr_pkg::OP_ADC: sum = add8(i_acc, i_opnd, i_carry);
                    csbr_pkg::OP_SUB: sum = add8(i_acc, ~i_opnd, 1'b1);
                    default: sum = add8(i_acc, ~i_opnd, i_carry);
                endcase
                o_res = sum[7:0];
                o_c = sum[10];
                o_ac = sum[8];
                o_ov = sum[10] ^ sum[9];
                o_upd_arith = 1'b1;
            end
            csbr_pkg::OP_INC, csbr_pkg::OP_DEC: begin
                step = add8(i_opnd, (i_op == csbr_pkg::OP_INC) ? 8'h01 : 8'hff, 1'b0);
                o_res = step[7:0];
                o_upd_z = 1'b1;
            end
            csbr_pkg::OP_AND: begin
                o_res = i_acc & i_opnd;
                o_upd_z = 1'b1;
            end
            csbr_pkg::OP_OR: begin
                o_res = i_acc | i_opnd;
                o_upd_z = 1'b1;
            end
            csbr_pkg::OP_XOR: begin
                o_res = i_acc ^ i_opnd;
                o_upd_z = 1'b1;
            end
            csbr_pkg::OP_RLC: begin
                o_res = {i_opnd[6:0], i_carry};
                o_c = i_opnd[7];
                o_upd_c = 1'b1;
            end
            csbr_pkg::OP_RRC: begin
                o_res = {i_carry, i_opnd[7:1]};
                o_c = i_opnd[0];
                o_upd_c = 1'b1;
            end
            csbr_pkg::OP_MOVA: o_res = i_opnd;
            csbr_pkg::OP_MOVM: o_res = i_acc;
            default: o_res = 8'h00;
        endcase
    end

    assign o_z = (o_res == 8'h00);

endmodule

//--- logic/csbr_core.sv
/*
 * Core special function registers: bank select, working register, program counter
 * low byte jumps, table read sequencing and the status flags.
 * Assumes the execution core, watchdog and reset controller run on i_core_clk and
 * hand over one decoded operation at a time, with its operand address resolved.
 */
`timescale 1ns/1ps
`include "csbr_defs.svh"

// Operation
// - The bank pointer holds one writable bit 0 choosing bank 0 or 1, upper bits read zero.
// - Register-to-register data only passes through the working register, which holds results.
// - Writing the program counter low byte jumps inside the current page, upper bits kept.
// - A write of the program counter low byte is followed by one dummy cycle.
// - A table read fetches the word at the table pointer, high byte to table high, low to dest.
// - Writes to the status register change the arithmetic flags but never the system flags.
// - The watchdog time-out flag (bit 5) sets on time-out and clears on power-up, clear or halt.
// - The power-down flag (bit 4) sets on halt and clears on power-up or watchdog clear.
// - Carry (bit 0) is add carry or subtract no-borrow, and is also moved by rotates.
// - Aux carry (bit 1) is the carry or no-borrow between the low and high nibble.
// - Zero (bit 2) is set when an arithmetic or logic result is zero.
// - Overflow (bit 3) is the carry into bit 7 differing from the carry out of it.
// - The status register is never saved automatically on interrupt or call.
// - Status bits 7 and 6 read zero; system flags are read-only and reset to zero.
// - Direct addressing always reaches bank 0; bank 1 only through indirect addressing.
// - Reset returns the bank to 0 unless it is a watchdog reset in idle or sleep.
module csbr_core #(
    parameter int PC_W = 10
) (
    // clock and reset
    input logic i_core_clk,
    input logic i_rstn,
    input logic i_soft_rst,
    input logic i_rst_wdt_sleep,
    // operation from the execution core
    input logic i_op_valid,
    input csbr_pkg::csbr_op_e i_op,
    input logic [7:0] i_op_addr,
    input logic i_op_indirect,
    input logic i_op_dest_acc,
    input logic [7:0] i_mem_rdata,
    input logic [PC_W-1:0] i_pc,
    // system events
    input logic i_wdt_timeout,
    input logic i_watchdog_clear_instruction,
    input logic i_halt,
    // program memory table port
    input logic i_prog_valid,
    input logic [15:0] i_prog_data,
    output logic o_prog_rd,
    output logic [PC_W-1:0] o_prog_addr,
    // data memory write port
    output logic o_mem_we,
    output logic [7:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_bank,
    // program counter load
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_target,
    // state
    output logic o_busy,
    output logic o_bank_sel,
    output logic [7:0] o_acc,
    output logic [7:0] o_status
);

    function automatic logic is_sfr(input logic [7:0] a);
        return (a == `CSBR_ADDR_BP) || (a == `CSBR_ADDR_ACC) || (a == `CSBR_ADDR_PCL) ||
               (a == `CSBR_ADDR_TABLE_POINTER) || (a == `CSBR_ADDR_TABLE_HIGH_BYTE) ||
               (a == `CSBR_ADDR_STATUS);
    endfunction

    csbr_pkg::csbr_state_e state_r, state_nxt;
    logic bank_r, bank_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] table_pointer_r, table_pointer_nxt;
    logic [7:0] table_high_byte_r, table_high_byte_nxt;
    logic c_r, ac_r, z_r, ov_r, to_r, pdf_r;
    logic c_nxt, ac_nxt, z_nxt, ov_nxt, to_nxt, pdf_nxt;
    logic tbl_acc_r, tbl_ind_r;
    logic [7:0] tbl_addr_r;
    logic mem_we_r, mem_bank_r, pc_load_r, prog_rd_r, busy_r;
    logic [7:0] mem_addr_r, mem_wdata_r;
    logic [PC_W-1:0] pc_target_r, prog_addr_r;

    logic [7:0] alu_res;
    logic alu_c, alu_ac, alu_ov, alu_z, upd_arith, upd_z, upd_c;
    logic [7:0] status_rd, sfr_rd, operand;

    // status reads with bits 7 and 6 as zero
    assign status_rd = {2'b00, to_r, pdf_r, ov_r, z_r, ac_r, c_r};

    always_comb begin
        case (i_op_addr)
            `CSBR_ADDR_BP: sfr_rd = {7'h00, bank_r};
            `CSBR_ADDR_ACC: sfr_rd = acc_r;
            `CSBR_ADDR_PCL: sfr_rd = i_pc[7:0];
            `CSBR_ADDR_TABLE_POINTER: sfr_rd = table_pointer_r;
            `CSBR_ADDR_TABLE_HIGH_BYTE: sfr_rd = table_high_byte_r;
            `CSBR_ADDR_STATUS: sfr_rd = status_rd;
            default: sfr_rd = 8'h00;
        endcase
    end

    assign operand = is_sfr(i_op_addr) ? sfr_rd : i_mem_rdata;

    csbr_alu u_alu (
        .i_op(i_op),
        .i_acc(acc_r),
        .i_opnd(operand),
        .i_carry(c_r),
        .o_res(alu_res),
        .o_c(alu_c),
        .o_ac(alu_ac),
        .o_ov(alu_ov),
        .o_z(alu_z),
        .o_upd_arith(upd_arith),
        .o_upd_z(upd_z),
        .o_upd_c(upd_c)
    );

    // operation acceptance; nothing is taken during a table wait or dummy cycle
    wire op_take = i_op_valid && (state_r == csbr_pkg::ST_IDLE);
    wire is_tbl = op_take && (i_op == csbr_pkg::OP_TABRD);
    wire tbl_done = (state_r == csbr_pkg::ST_TBL) && i_prog_valid;
    wire op_acc = (i_op == csbr_pkg::OP_MOVA) || (i_op != csbr_pkg::OP_MOVM && i_op_dest_acc);

    // one write path serves operation results and table low bytes
    wire wr_en = (op_take && !is_tbl && i_op != csbr_pkg::OP_NOP) || tbl_done;
    wire wr_acc = tbl_done ? tbl_acc_r : op_acc;
    wire [7:0] wr_addr = tbl_done ? tbl_addr_r : i_op_addr;
    wire wr_ind = tbl_done ? tbl_ind_r : i_op_indirect;
    wire [7:0] wr_data = tbl_done ? i_prog_data[7:0] : alu_res;
    wire wr_mem = wr_en && !wr_acc;
    wire wr_sfr = wr_mem && is_sfr(wr_addr);
    wire wr_ext = wr_mem && !is_sfr(wr_addr);
    wire wr_bp = wr_sfr && (wr_addr == `CSBR_ADDR_BP);
    wire wr_accr = wr_sfr && (wr_addr == `CSBR_ADDR_ACC);
    wire wr_pcl = wr_sfr && (wr_addr == `CSBR_ADDR_PCL);
    wire wr_table_pointer = wr_sfr && (wr_addr == `CSBR_ADDR_TABLE_POINTER);
    wire wr_stat = wr_sfr && (wr_addr == `CSBR_ADDR_STATUS);

    // flag candidates, only for a taken operation that affects them
    wire take_arith = op_take && upd_arith;
    wire take_z = op_take && (upd_arith || upd_z);
    wire take_c = op_take && (upd_arith || upd_c);

    always_comb begin
        state_nxt = csbr_pkg::ST_IDLE;
        case (state_r)
            csbr_pkg::ST_IDLE: begin
                if (is_tbl) begin
                    state_nxt = csbr_pkg::ST_TBL;
                end else if (wr_pcl) begin
                    state_nxt = csbr_pkg::ST_DUMMY;
                end
            end
            csbr_pkg::ST_TBL: begin
                if (!i_prog_valid) begin
                    state_nxt = csbr_pkg::ST_TBL;
                end else if (wr_pcl) begin
                    state_nxt = csbr_pkg::ST_DUMMY;
                end
            end
            csbr_pkg::ST_DUMMY: state_nxt = csbr_pkg::ST_IDLE;
            default: state_nxt = csbr_pkg::ST_IDLE;
        endcase
        if (i_soft_rst) begin
            state_nxt = csbr_pkg::ST_IDLE;
        end
    end

    // bank keeps its value only for a watchdog reset out of idle or sleep
    assign bank_nxt = i_soft_rst ? (i_rst_wdt_sleep && bank_r) :
                      wr_bp ? wr_data[`CSBR_BIT_BANK] : bank_r;
    assign acc_nxt = (wr_en && wr_acc) || wr_accr ? wr_data : acc_r;
    assign table_pointer_nxt = wr_table_pointer ? wr_data : table_pointer_r;
    assign table_high_byte_nxt = tbl_done ? i_prog_data[15:8] : table_high_byte_r;

    // a flag from the operation wins over the same bit written as data
    assign c_nxt = take_c ? alu_c : wr_stat ? wr_data[`CSBR_BIT_C] : c_r;
    assign ac_nxt = take_arith ? alu_ac : wr_stat ? wr_data[`CSBR_BIT_AC] : ac_r;
    assign z_nxt = take_z ? alu_z : wr_stat ? wr_data[`CSBR_BIT_Z] : z_r;
    assign ov_nxt = take_arith ? alu_ov : wr_stat ? wr_data[`CSBR_BIT_OV] : ov_r;
    // system flags ignore data writes; a set wins over a clear in the same cycle
    assign to_nxt = i_wdt_timeout ? 1'b1 : (i_watchdog_clear_instruction || i_halt) ? 1'b0 : to_r;
    assign pdf_nxt = i_halt ? 1'b1 : i_watchdog_clear_instruction ? 1'b0 : pdf_r;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= csbr_pkg::ST_IDLE;
            bank_r <= `CSBR_BANK_RST;
            to_r <= `CSBR_SYS_RST;
            pdf_r <= `CSBR_SYS_RST;
        end else begin
            state_r <= state_nxt;
            bank_r <= bank_nxt;
            to_r <= to_nxt;
            pdf_r <= pdf_nxt;
        end
    end

    // flags live only here and no stack path exists for them
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {c_r, ac_r, z_r, ov_r} <= {4{`CSBR_FLAG_RST}};
            acc_r <= `CSBR_BYTE_RST;
            table_pointer_r <= `CSBR_BYTE_RST;
            table_high_byte_r <= `CSBR_BYTE_RST;
        end else begin
            {c_r, ac_r, z_r, ov_r} <= {c_nxt, ac_nxt, z_nxt, ov_nxt};
            acc_r <= acc_nxt;
            table_pointer_r <= table_pointer_nxt;
            table_high_byte_r <= table_high_byte_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tbl_acc_r <= 1'b0;
            tbl_ind_r <= 1'b0;
            tbl_addr_r <= `CSBR_BYTE_RST;
        end else if (is_tbl) begin
            tbl_acc_r <= i_op_dest_acc;
            tbl_ind_r <= i_op_indirect;
            tbl_addr_r <= i_op_addr;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_we_r <= 1'b0;
            mem_addr_r <= `CSBR_BYTE_RST;
            mem_wdata_r <= `CSBR_BYTE_RST;
            mem_bank_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_target_r <= '0;
            prog_rd_r <= 1'b0;
            prog_addr_r <= '0;
            busy_r <= 1'b0;
        end else begin
            mem_we_r <= wr_ext;
            mem_addr_r <= wr_addr;
            mem_wdata_r <= wr_data;
            mem_bank_r <= wr_ind && bank_r;
            pc_load_r <= wr_pcl;
            pc_target_r <= {i_pc[PC_W-1:8], wr_data};
            prog_rd_r <= is_tbl;
            prog_addr_r <= {i_pc[PC_W-1:8], table_pointer_r};
            busy_r <= (state_nxt != csbr_pkg::ST_IDLE);
        end
    end

    assign o_mem_we = mem_we_r;
    assign o_mem_addr = mem_addr_r;
    assign o_mem_wdata = mem_wdata_r;
    assign o_mem_bank = mem_bank_r;
    assign o_pc_load = pc_load_r;
    assign o_pc_target = pc_target_r;
    assign o_prog_rd = prog_rd_r;
    assign o_prog_addr = prog_addr_r;
    assign o_busy = busy_r;
    assign o_bank_sel = bank_r;
    assign o_acc = acc_r;
    assign o_status = status_rd;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    chk_bank_write: assert property (wr_bp && !i_soft_rst |=>
        o_bank_sel == $past(wr_data[0])) else $error("bank bit not written");
    chk_move_via_acc: assert property (op_take && i_op == csbr_pkg::OP_MOVA |=>
        o_acc == $past(operand)) else $error("move to working register lost");
    chk_pcl_jump: assert property (wr_pcl |=> o_pc_load &&
        o_pc_target == {$past(i_pc[PC_W-1:8]), $past(wr_data)}) else $error("bad jump");
    chk_dummy_cycle: assert property (wr_pcl && !i_soft_rst |=>
        o_busy ##1 !o_busy) else $error("dummy cycle not one cycle");
    chk_table_high: assert property (tbl_done |=>
        table_high_byte_r == $past(i_prog_data[15:8]) && !o_busy) else $error("table high wrong");
    chk_status_sys_kept: assert property (wr_stat && !i_wdt_timeout && !i_halt &&
        !i_watchdog_clear_instruction |=> $stable(o_status[5:4])) else $error("status write hit system flags");
    chk_timeout_flag: assert property (i_wdt_timeout |=> o_status[5] ##1
        (o_status[5] || $past(i_watchdog_clear_instruction || i_halt))) else $error("time-out flag wrong");
    chk_halt_flags: assert property (i_halt && !i_wdt_timeout |=>
        o_status[4] && !o_status[5]) else $error("halt flags wrong");
    chk_add_carry: assert property (op_take && i_op == csbr_pkg::OP_ADD |=>
        o_status[0] == ($past({1'b0, acc_r} + {1'b0, operand}) > 9'h0ff)) else
        $error("add carry wrong");
    chk_zero_flag: assert property (op_take && i_op == csbr_pkg::OP_XOR |=>
        o_status[2] == ($past(acc_r) == $past(operand))) else $error("zero flag wrong");
    chk_status_top: assert property (o_status[7:6] == 2'b00)
        else $error("status top bits not zero");
    chk_direct_bank0: assert property (wr_ext && !wr_ind |=>
        o_mem_we && !o_mem_bank) else $error("direct write left bank 0");
    chk_reset_bank: assert property (i_soft_rst && !i_rst_wdt_sleep |=>
        !o_bank_sel) else $error("bank not reset");
    chk_mov_flags: assert property (op_take && i_op == csbr_pkg::OP_MOVA && !wr_stat |=>
        $stable(o_status[3:0])) else $error("move changed flags");

    cov_table_read: cover property (is_tbl ##[1:8] tbl_done);
    cov_pcl_jump: cover property (wr_pcl ##1 o_busy ##1 op_take);
    cov_sub_borrow: cover property (op_take && i_op == csbr_pkg::OP_SUB && !alu_c);
    cov_wdt_keep_bank: cover property (bank_r && i_soft_rst && i_rst_wdt_sleep);

endmodule

//--- test/csbr_prog_model.sv
/*
 * Program memory model answering table fetches of the core register block.
 * Assumes fetch requests are one-cycle pulses on the core clock.
 */
`timescale 1ns/1ps
module csbr_prog_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // fetch request
    input wire logic i_prog_rd,
    input wire logic [9:0] i_prog_addr,
    input wire logic [3:0] i_delay,
    // fetch answer
    output logic o_prog_valid,
    output logic [15:0] o_prog_data
);
    logic [15:0] word;
    initial begin
        o_prog_valid = 1'b0;
        o_prog_data = 16'h0000;
        forever begin
            @(posedge i_core_clk);
            if (i_rstn === 1'b1 && i_prog_rd === 1'b1) begin
                // high byte and low byte differ so a swap is seen
                word = {i_prog_addr[7:0] ^ 8'hc3, i_prog_addr[7:0] ^ 8'h5a};
                repeat (i_delay) @(posedge i_core_clk);
                o_prog_valid <= 1'b1;
                o_prog_data <= word;
                @(posedge i_core_clk);
                o_prog_valid <= 1'b0;
                // stale word is not left on the bus
                o_prog_data <= ~word;
            end
        end
    end
endmodule

//--- test/testbench.sv
/*
 * Self-checking bench of the core status and bank registers.
 * Assumes csbr_core and the program memory model are compiled before it.
 */
`timescale 1ns/1ps
`include "csbr_defs.svh"
module testbench;
    logic clk, rstn, soft_rst, wdt_sleep, op_valid, ind, dacc, wdt_to, watchdog_clear_instruction, halt;
    csbr_pkg::csbr_op_e op;
    logic [7:0] addr, rdata, acc, status, mem_addr, mem_wdata;
    logic [9:0] pc, prog_addr, pc_target;
    logic prog_valid, prog_rd, mem_we, mem_bank, pc_load, busy, bank_sel;
    logic [15:0] prog_data;
    logic [3:0] delay;
    int fails = 0;
    int samples_checked = 0;

    csbr_core #(.PC_W(10)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_soft_rst(soft_rst),
        .i_rst_wdt_sleep(wdt_sleep), .i_op_valid(op_valid), .i_op(op), .i_op_addr(addr),
        .i_op_indirect(ind), .i_op_dest_acc(dacc), .i_mem_rdata(rdata), .i_pc(pc),
        .i_wdt_timeout(wdt_to), .i_watchdog_clear_instruction(watchdog_clear_instruction), .i_halt(halt),
        .i_prog_valid(prog_valid), .i_prog_data(prog_data), .o_prog_rd(prog_rd),
        .o_prog_addr(prog_addr), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .o_mem_bank(mem_bank), .o_pc_load(pc_load),
        .o_pc_target(pc_target), .o_busy(busy), .o_bank_sel(bank_sel), .o_acc(acc),
        .o_status(status));
    csbr_prog_model partner (.i_core_clk(clk), .i_rstn(rstn), .i_prog_rd(prog_rd),
        .i_prog_addr(prog_addr), .i_delay(delay), .o_prog_valid(prog_valid),
        .o_prog_data(prog_data));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one operation, taken at the next edge; outputs sampled in the cycle after
    task automatic do_op(input csbr_pkg::csbr_op_e o, input logic [7:0] a, input logic i,
                         input logic d, input logic [7:0] rd);
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        addr <= a;
        ind <= i;
        dacc <= d;
        rdata <= rd;
        @(posedge clk);
        op_valid <= 1'b0;
        rdata <= ~rd;
        #1;
    endtask

    task automatic load_acc(input logic [7:0] v);
        do_op(csbr_pkg::OP_MOVA, 8'h40, 1'b0, 1'b1, v);
    endtask

    task automatic pulse(input logic w, input logic c, input logic h, input logic s,
                         input logic ws);
        @(posedge clk);
        {wdt_to, watchdog_clear_instruction, halt, soft_rst, wdt_sleep} <= {w, c, h, s, ws};
        @(posedge clk);
        {wdt_to, watchdog_clear_instruction, halt, soft_rst, wdt_sleep} <= 5'h00;
        #1;
    endtask

    task automatic test_reset();
        chk("status_high", 16'h0000, {12'h000, status[7:4]});
        chk("bank_rst", 16'h0000, {15'h0000, bank_sel});
    endtask

    task automatic test_bank();
        load_acc(8'hff);
        chk("acc_load", 16'h00ff, {8'h00, acc});
        do_op(csbr_pkg::OP_MOVM, `CSBR_ADDR_BP, 1'b0, 1'b0, 8'h00);
        chk("bank_set", 16'h0001, {15'h0000, bank_sel});
        do_op(csbr_pkg::OP_MOVA, `CSBR_ADDR_BP, 1'b0, 1'b1, 8'h00);
        chk("bank_read", 16'h0001, {8'h00, acc});
        load_acc(8'haa);
        do_op(csbr_pkg::OP_MOVM, 8'h40, 1'b1, 1'b0, 8'h00);
        chk("ind_write", 16'h1aa, {7'h00, mem_we, mem_wdata});
        chk("ind_bank", 16'h0140, {7'h00, mem_bank, mem_addr});
        do_op(csbr_pkg::OP_MOVM, 8'h40, 1'b0, 1'b0, 8'h00);
        chk("dir_bank", 16'h0100, {7'h00, mem_we, 7'h00, mem_bank});
        pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        chk("bank_wdt_keep", 16'h0001, {15'h0000, bank_sel});
        pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk("bank_soft_rst", 16'h0000, {15'h0000, bank_sel});
    endtask

    task automatic test_flags();
        // operation, acc, operand, result, flags {ov,z,ac,c}
        logic [31:0] tbl [6] = '{{4'h3, 8'h7f, 8'h01, 8'h80, 4'ha},
            {4'h3, 8'hff, 8'h01, 8'h00, 4'h7}, {4'h5, 8'h05, 8'h05, 8'h00, 4'h7},
            {4'h5, 8'h00, 8'h01, 8'hff, 4'h0}, {4'hc, 8'h00, 8'h81, 8'h02, 4'h1},
            {4'h7, 8'hf0, 8'h0f, 8'h00, 4'h5}};
        for (int k = 0; k < 6; k++) begin
            load_acc(tbl[k][27:20]);
            do_op(csbr_pkg::csbr_op_e'(tbl[k][31:28]), 8'h40, 1'b0, 1'b1, tbl[k][19:12]);
            chk("alu_res", {8'h00, tbl[k][11:4]}, {8'h00, acc});
            chk("alu_flags", {12'h000, tbl[k][3:0]}, {12'h000, status[3:0]});
        end
    endtask

    task automatic test_status();
        pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        load_acc(8'hff);
        do_op(csbr_pkg::OP_MOVM, `CSBR_ADDR_STATUS, 1'b0, 1'b0, 8'h00);
        chk("status_wr_ff", 16'h001f, {8'h00, status});
        load_acc(8'h00);
        do_op(csbr_pkg::OP_MOVM, `CSBR_ADDR_STATUS, 1'b0, 1'b0, 8'h00);
        chk("status_wr_00", 16'h0010, {8'h00, status});
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("timeout_set", 16'h0030, {8'h00, status});
        pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("halt", 16'h0010, {8'h00, status});
        pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("clear_wdt", 16'h0000, {8'h00, status});
    endtask

    task automatic test_jump();
        load_acc(8'h3c);
        @(posedge clk);
        {op_valid, op, addr, ind, dacc} <= {1'b1, csbr_pkg::OP_MOVM, `CSBR_ADDR_PCL, 2'b00};
        @(posedge clk);
        // offered during the dummy cycle, so it must be dropped
        {op, addr, dacc, rdata} <= {csbr_pkg::OP_MOVA, 8'h40, 1'b1, 8'h77};
        #1;
        chk("pc_load", 16'h0103, {7'h00, pc_load, 6'h00, busy, busy});
        chk("pc_target", 16'h023c, {6'h00, pc_target});
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("dummy_end", 16'h003c, {7'h00, busy, acc});
    endtask

    task automatic test_table();
        int n;
        for (int k = 0; k < 2; k++) begin
            delay <= k ? 4'h0 : 4'h3;
            load_acc(8'h12 + k);
            do_op(csbr_pkg::OP_MOVM, `CSBR_ADDR_TABLE_POINTER, 1'b0, 1'b0, 8'h00);
            do_op(csbr_pkg::OP_TABRD, 8'h41, 1'b0, k[0], 8'h00);
            chk("prog_rd", 16'h0003, {14'h0000, prog_rd, busy});
            chk("prog_addr", {6'h00, 2'h2, 8'(8'h12 + k)}, {6'h00, prog_addr});
            n = 0;
            while (busy !== 1'b0 && n < 20) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("tbl_busy", 16'h0000, {15'h0000, busy});
            if (k == 0) chk("tbl_low_mem", 16'h0148, {7'h00, mem_we, mem_wdata});
            else chk("tbl_low_acc", 16'h0049, {8'h00, acc});
            do_op(csbr_pkg::OP_MOVA, `CSBR_ADDR_TABLE_HIGH_BYTE, 1'b0, 1'b1, 8'h00);
            chk("tbl_high", {8'h00, 8'(8'h12 + k) ^ 8'hc3}, {8'h00, acc});
        end
    endtask

    initial begin
        {rstn, soft_rst, wdt_sleep, op_valid, ind, dacc, wdt_to, watchdog_clear_instruction, halt} = 9'h000;
        op = csbr_pkg::OP_NOP;
        {addr, rdata} = 16'h0000;
        pc = 10'h2a5;
        delay = 4'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        test_reset();
        test_bank();
        test_flags();
        test_status();
        test_jump();
        test_table();
        give_verdict();
    end

    initial begin
        #(25 * 4000);
        fails++;
        give_verdict();
    end
endmodule
